// [rtl/sbcw_pkg.sv]
// Function
// R1 - Two watchdog behaviours, time-out or window, one select bit, time-out after reset.
// R2 - Type and timing change only in normal mode; stop mode keeps configuration.
// R3 - Long open window after reset release in init; off in sleep and restart.
// R4 - Programming new timing restarts the timer at once with the new setting.
// R5 - A valid write to the watchdog register triggers when chip select rises.
// R6 - Coming from init, restart or stop starts a 200ms long open window.
// R7 - Seven periods from 10ms to 1000ms, shared by both watchdog behaviours.
// R8 - A failure enters restart or fail-safe as configured and updates failure count.
// R9 - After a watchdog reset releases, start long window and request normal mode.
// R10 - Software development mode disables the watchdog; no reset from it.
// R11 - Each bad trigger or expiry increments failure count, saturating at 01 or 10.
// R12 - Failure count clears after good trigger and whenever the watchdog is off; code clears off only in sleep, disabled stop, non-watchdog fail-safe.
// R13 - Time-out: trigger anytime in period restarts it; expiry resets the chip.
// R14 - Window: closed window 60% of period then open window; trigger restarts closed.
// R15 - Host places window triggers between 0.72 and 1.20 of the nominal period.
// R16 - Window: trigger in closed window or expiry drives reset low.
// R17 - Watchdog register write needs even parity over all 8 bits, reserved bit included.
// R18 - Parity failure discards the whole write and sets the command error flag.
// R19 - Host disables for stop by setting arm bit a, then arm bit b.
// R20 - Sequence error clears arm bit b; restarting sequence clears set arm bit a.
// R21 - Stop trigger or return to normal re-enables with long window, clears arm bits.
// R22 - Bus wake in stop restarts watchdog, interrupts, pulls receive low if enabled.
// R23 - A failure holds reset low and releases it after the reset delay time.
// R24 - No valid trigger before the long open window ends counts as a failure.
// R25 - All windows and periods are counts of the internal oscillator clock.
package sbcw_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_WD = 8'h00;
	localparam logic [7:0] OFS_WAKE = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_CFG = 8'h0c;
	// Watchdog register fields
	localparam int WD_SEL_LSB = 0;
	localparam int WD_RSVD_BIT = 3;
	localparam int WD_FS_BIT = 4;
	localparam int TIMEOUT_OR_WINDOW_SELECT_BIT = 5;
	localparam int WD_ARMB_BIT = 6;
	localparam int WD_CHK_BIT = 7;
	// Wake register fields
	localparam int WK_ARMA_BIT = 0;
	localparam int WK_BUSEN_BIT = 1;
	// Status register fields
	localparam int ST_ERR_BIT = 2;
	// Reset values, failure config code and failure count limits
	localparam logic [2:0] PERIOD_SEL_RST = 3'h4;
	localparam logic BUS_WAKE_EN_RST = 1'b1;
	localparam logic [1:0] FAIL_CFG_RST = 2'h0;
	localparam logic [1:0] FAIL_CFG_TWO = 2'h1;
	localparam logic [1:0] FAIL_MAX_LOW = 2'h1;
	localparam logic [1:0] FAIL_MAX_HIGH = 2'h2;
	// Chip mode codes from the mode controller
	localparam logic [2:0] MODE_INIT = 3'h0;
	localparam logic [2:0] MODE_NORMAL = 3'h1;
	localparam logic [2:0] MODE_STOP = 3'h2;
	localparam logic [2:0] MODE_SLEEP = 3'h3;
	localparam logic [2:0] MODE_RESTART = 3'h4;
	localparam logic [2:0] MODE_FAILSAFE = 3'h5;
	// Timing
	localparam int CLK_KHZ = 25000;
	localparam int LONG_WINDOW_MS = 200;
	localparam int RESET_DELAY_MS = 10;
	localparam int CLOSED_PCT = 60;
	localparam int PERIOD_MS [8] = '{10, 10, 20, 50, 100, 200, 500, 1000};
	typedef enum logic [4:0] {
		SBCW_OFF = 5'b00001,
		SBCW_LONG = 5'b00010,
		SBCW_CLOSED = 5'b00100,
		SBCW_OPEN = 5'b01000,
		SBCW_RST = 5'b10000
	} sbcw_state_t;
endpackage

// [rtl/sbcw_watchdog.sv]
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module sbcw_watchdog #(
	parameter int CYC_PER_MS = sbcw_pkg::CLK_KHZ,
	parameter int RESET_DELAY_MS = sbcw_pkg::RESET_DELAY_MS
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Serial frame pin
	input wire logic i_chip_select_n,
	// Chip mode controller
	input wire logic [2:0] i_chip_mode,
	input wire logic i_dev_mode,
	input wire logic i_ro_released,
	input wire logic i_can_wake,
	output logic o_reset_output_pin,
	output logic o_wd_failure,
	output logic o_fail_to_failsafe,
	output logic o_normal_request,
	output logic o_wake_irq,
	output logic o_rxd_pull_low
);
	localparam logic [31:0] LONG_CYC = 32'(sbcw_pkg::LONG_WINDOW_MS * CYC_PER_MS);
	localparam logic [31:0] RST_CYC = 32'(RESET_DELAY_MS * CYC_PER_MS);

	function automatic logic [31:0] period_cyc(input logic [2:0] sel);
		period_cyc = 32'(sbcw_pkg::PERIOD_MS[sel] * CYC_PER_MS);
	endfunction

	function automatic logic [31:0] closed_cyc(input logic [2:0] sel);
		logic [63:0] p;
		p = 64'(period_cyc(sel)) * 64'(sbcw_pkg::CLOSED_PCT);
		closed_cyc = 32'(p / 64'd100);
	endfunction

	function automatic logic [31:0] load_of(input logic [31:0] cyc);
		load_of = (cyc > 32'h1) ? cyc - 32'h1 : 32'h0;
	endfunction

	function automatic logic in_mode(input logic [2:0] mode, input logic [2:0] code);
		in_mode = (mode == code);
	endfunction

	sbcw_pkg::sbcw_state_t state;
	logic [31:0] cnt;
	logic csn_meta;
	logic csn_sync;
	logic csn_prev;
	logic [2:0] mode_prev;
	logic pend;
	logic [7:0] pend_data;
	logic win_sel;
	logic [2:0] period_sel;
	logic fs_sel;
	logic arm_a;
	logic arm_b;
	logic bus_wake_en;
	logic [1:0] fail_cfg;
	logic [1:0] fail_cnt;
	logic cmd_err;
	logic fs_by_wd;

	logic csn_rise;
	logic trig_ok;
	logic trig_bad;
	logic cfg_write;
	logic stop_off;
	logic run_allowed;
	logic expiry;
	logic failure;
	logic wake_hit;
	logic back_to_normal;
	logic in_stop;
	logic next_win;
	logic [2:0] next_sel;
	logic [1:0] fail_max;

	// Chip select is a pin: two flops before any logic looks at it
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			csn_meta <= 1'b1;
			csn_sync <= 1'b1;
			csn_prev <= 1'b1;
		end else begin
			csn_meta <= i_chip_select_n;
			csn_sync <= csn_meta;
			csn_prev <= csn_sync;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_prev <= sbcw_pkg::MODE_INIT;
		end else begin
			mode_prev <= i_chip_mode;
		end
	end

	always_comb begin
		in_stop = in_mode(i_chip_mode, sbcw_pkg::MODE_STOP);
		csn_rise = csn_sync & ~csn_prev;
		trig_ok = csn_rise & pend & ~(^pend_data); // R5 R17
		trig_bad = csn_rise & pend & (^pend_data); // R18
		cfg_write = trig_ok & in_mode(i_chip_mode, sbcw_pkg::MODE_NORMAL); // R2
		next_win = cfg_write ? pend_data[sbcw_pkg::TIMEOUT_OR_WINDOW_SELECT_BIT] : win_sel;
		next_sel = cfg_write ? pend_data[sbcw_pkg::WD_SEL_LSB +: 3] : period_sel;
		stop_off = arm_a & arm_b;
		// Off in sleep, restart, fail-safe and development mode; init waits for reset release
		run_allowed = ~i_dev_mode & // R10
			((in_mode(i_chip_mode, sbcw_pkg::MODE_INIT) & i_ro_released) | // R3
			in_mode(i_chip_mode, sbcw_pkg::MODE_NORMAL) |
			(in_stop & ~stop_off));
		// A last-cycle trigger still counts as in time
		expiry = (cnt == 32'h0) & ~trig_ok;
		failure = run_allowed & (
			((state == sbcw_pkg::SBCW_LONG) & expiry) | // R24
			((state == sbcw_pkg::SBCW_OPEN) & expiry) | // R13 R16
			((state == sbcw_pkg::SBCW_CLOSED) & trig_ok)); // R16
		wake_hit = i_can_wake & in_stop & stop_off & bus_wake_en; // R22
		back_to_normal = in_mode(i_chip_mode, sbcw_pkg::MODE_NORMAL) &
			in_mode(mode_prev, sbcw_pkg::MODE_STOP);
		fail_max = (fail_cfg == sbcw_pkg::FAIL_CFG_TWO) ?
			sbcw_pkg::FAIL_MAX_LOW : sbcw_pkg::FAIL_MAX_HIGH;
	end

	// Watchdog timer: all windows are oscillator cycle counts
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin // R25
		if (!i_reset_n) begin
			state <= sbcw_pkg::SBCW_OFF;
			cnt <= 32'h0;
		end else if (state == sbcw_pkg::SBCW_RST) begin
			if (cnt == 32'h0) begin
				state <= sbcw_pkg::SBCW_LONG; // R9
				cnt <= load_of(LONG_CYC);
			end else begin
				cnt <= cnt - 32'h1; // R23
			end
		end else if (!run_allowed) begin
			state <= sbcw_pkg::SBCW_OFF; // R3
			cnt <= 32'h0;
		end else if (back_to_normal || state == sbcw_pkg::SBCW_OFF) begin
			state <= sbcw_pkg::SBCW_LONG; // R6 R21
			cnt <= load_of(LONG_CYC);
		end else if (failure) begin
			state <= sbcw_pkg::SBCW_RST; // R23
			cnt <= load_of(RST_CYC);
		end else if (trig_ok) begin
			// New timing takes effect at once on the restarted period
			if (next_win) begin // R1 R4 R14
				state <= sbcw_pkg::SBCW_CLOSED;
				cnt <= load_of(closed_cyc(next_sel));
			end else begin // R13
				state <= sbcw_pkg::SBCW_OPEN;
				cnt <= load_of(period_cyc(next_sel)); // R7
			end
		end else if (state == sbcw_pkg::SBCW_CLOSED && cnt == 32'h0) begin
			state <= sbcw_pkg::SBCW_OPEN; // R14
			cnt <= load_of(period_cyc(period_sel) - closed_cyc(period_sel));
		end else begin
			cnt <= cnt - 32'h1;
		end
	end

	// Watchdog register write waits for the end of the serial frame
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend <= 1'b0;
			pend_data <= 8'h00;
		end else if (i_wr && i_addr == sbcw_pkg::OFS_WD) begin
			pend <= 1'b1;
			pend_data <= i_wdata;
		end else if (csn_rise) begin
			pend <= 1'b0; // R5
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			win_sel <= 1'b0; // R1
			period_sel <= sbcw_pkg::PERIOD_SEL_RST;
			fs_sel <= 1'b0;
		end else if (cfg_write) begin // R2 R18
			win_sel <= pend_data[sbcw_pkg::TIMEOUT_OR_WINDOW_SELECT_BIT];
			period_sel <= pend_data[sbcw_pkg::WD_SEL_LSB +: 3];
			fs_sel <= pend_data[sbcw_pkg::WD_FS_BIT];
		end
	end

	// Stop-mode disable sequence
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			arm_a <= 1'b0;
			arm_b <= 1'b0;
		end else if ((trig_ok && in_stop) || wake_hit || back_to_normal) begin
			arm_a <= 1'b0; // R21 R22
			arm_b <= 1'b0;
		end else begin
			if (i_wr && i_addr == sbcw_pkg::OFS_WAKE &&
				in_mode(i_chip_mode, sbcw_pkg::MODE_NORMAL) &&
				i_wdata[sbcw_pkg::WK_ARMA_BIT]) begin
				arm_a <= ~arm_a; // R20
			end
			if (cfg_write) begin
				// Arm bit b without arm bit a is a sequence error
				arm_b <= pend_data[sbcw_pkg::WD_ARMB_BIT] & arm_a; // R19 R20
			end
		end
	end

	// Bus wake enable is frozen once the disable sequence has begun
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bus_wake_en <= sbcw_pkg::BUS_WAKE_EN_RST;
		end else if (i_wr && i_addr == sbcw_pkg::OFS_WAKE && !arm_a &&
			in_mode(i_chip_mode, sbcw_pkg::MODE_NORMAL)) begin
			bus_wake_en <= i_wdata[sbcw_pkg::WK_BUSEN_BIT]; // R22
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fail_cfg <= sbcw_pkg::FAIL_CFG_RST;
		end else if (i_wr && i_addr == sbcw_pkg::OFS_CFG) begin
			fail_cfg <= i_wdata[1:0];
		end
	end

	// Fail-safe entered by the watchdog keeps the count until fail-safe is left
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fs_by_wd <= 1'b0;
		end else if (failure && fs_sel) begin
			fs_by_wd <= 1'b1;
		end else if (in_mode(mode_prev, sbcw_pkg::MODE_FAILSAFE) &&
			!in_mode(i_chip_mode, sbcw_pkg::MODE_FAILSAFE)) begin
			fs_by_wd <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fail_cnt <= 2'h0;
		end else if (failure) begin
			if (fail_cnt < fail_max) begin
				fail_cnt <= fail_cnt + 2'h1; // R8 R11
			end
		end else if (trig_ok ||
			(in_stop && stop_off) ||
			in_mode(i_chip_mode, sbcw_pkg::MODE_SLEEP) ||
			(in_mode(i_chip_mode, sbcw_pkg::MODE_FAILSAFE) && !fs_by_wd)) begin
			fail_cnt <= 2'h0; // R12
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cmd_err <= 1'b0;
		end else if (trig_bad) begin
			cmd_err <= 1'b1; // R18
		end else if (i_wr && i_addr == sbcw_pkg::OFS_STAT && i_wdata[sbcw_pkg::ST_ERR_BIT]) begin
			cmd_err <= 1'b0;
		end
	end

	// Reset output and mode controller requests
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reset_output_pin <= 1'b1;
			o_wd_failure <= 1'b0;
			o_normal_request <= 1'b0;
			o_fail_to_failsafe <= 1'b0;
		end else begin
			o_wd_failure <= failure; // R8
			o_fail_to_failsafe <= fs_sel;
			o_normal_request <= (state == sbcw_pkg::SBCW_RST) && (cnt == 32'h0); // R9
			if (failure) begin
				o_reset_output_pin <= 1'b0; // R13 R16 R23
			end else if (state == sbcw_pkg::SBCW_RST && cnt == 32'h0) begin
				o_reset_output_pin <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wake_irq <= 1'b0;
			o_rxd_pull_low <= 1'b0;
		end else begin
			o_wake_irq <= wake_hit; // R22
			if (wake_hit) begin
				o_rxd_pull_low <= 1'b1;
			end else if (!in_stop) begin
				o_rxd_pull_low <= 1'b0;
			end
		end
	end

	// Read data one cycle after the strobe; reserved bit 3 reads zero
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				sbcw_pkg::OFS_WD:
					o_rdata <= {^{arm_b, win_sel, fs_sel, period_sel}, arm_b, win_sel, fs_sel,
						1'b0, period_sel};
				sbcw_pkg::OFS_WAKE:
					o_rdata <= {6'h00, bus_wake_en, arm_a};
				sbcw_pkg::OFS_STAT:
					o_rdata <= {1'b0, state == sbcw_pkg::SBCW_RST, state == sbcw_pkg::SBCW_CLOSED,
						state == sbcw_pkg::SBCW_LONG, state == sbcw_pkg::SBCW_OFF, cmd_err, fail_cnt};
				sbcw_pkg::OFS_CFG:
					o_rdata <= {6'h00, fail_cfg};
				default:
					o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule

// [verif/sbcw_host_model.sv]
`timescale 1ns/1ns
module sbcw_host_model (
	// Clock
	input wire logic i_core_clk,
	// Read data from the watchdog
	input wire logic [7:0] i_rdata,
	// Register port and chip select
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	output logic o_chip_select_n
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_chip_select_n = 1'b1;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		// Released data shows garbage so a late sample cannot pass by luck
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_core_clk);
		o_rd <= 1'b0;
		@(posedge i_core_clk);
		d = i_rdata;
	endtask
	// Checksum is the caller's job, so bad parity can be sent on purpose
	task automatic trig(input logic [7:0] d);
		@(posedge i_core_clk);
		o_chip_select_n <= 1'b0;
		wr(8'h00, d);
		@(posedge i_core_clk);
		o_chip_select_n <= 1'b1;
	endtask
endmodule

// [verif/sbcw_watchdog_sva.sv]
`timescale 1ns/1ns
module sbcw_watchdog_chk #(
	parameter int CYC_PER_MS = 25000,
	parameter int RESET_DELAY_MS = 10
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Inputs watched
	input wire logic [7:0] i_addr,
	input wire logic i_rd,
	input wire logic [2:0] i_chip_mode,
	input wire logic i_dev_mode,
	input wire logic i_can_wake,
	// Outputs watched
	input wire logic [7:0] o_rdata,
	input wire logic o_reset_output_pin,
	input wire logic o_wd_failure,
	input wire logic o_normal_request,
	input wire logic o_wake_irq,
	input wire logic o_rxd_pull_low
);
	localparam int RD_CYC = CYC_PER_MS * RESET_DELAY_MS;
	int low_cnt;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) low_cnt <= 0;
		else if (o_reset_output_pin) low_cnt <= 0;
		else low_cnt <= low_cnt + 1;
	end
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);
	sequence s_fail;
		$fell(o_reset_output_pin) ##0 o_wd_failure;
	endsequence
	sequence s_release;
		$rose(o_reset_output_pin) ##0 low_cnt == RD_CYC;
	endsequence
	property p_fail;
		o_wd_failure |-> s_fail;
	endproperty
	a_fail: assert property (p_fail) else $error("failure without reset drop");
	property p_fall;
		$fell(o_reset_output_pin) |-> o_wd_failure;
	endproperty
	a_fall: assert property (p_fall) else $error("reset drop without failure");
	property p_hold;
		$rose(o_reset_output_pin) |-> s_release;
	endproperty
	a_hold: assert property (p_hold) else $error("reset low time wrong");
	property p_req;
		o_normal_request |-> s_release;
	endproperty
	a_req: assert property (p_req) else $error("normal request not at release");
	property p_dev;
		i_dev_mode [*3] |-> !o_wd_failure;
	endproperty
	a_dev: assert property (p_dev) else $error("failure in development mode");
	property p_sleep;
		(i_chip_mode == sbcw_pkg::MODE_SLEEP) [*3] |-> !o_wd_failure;
	endproperty
	a_sleep: assert property (p_sleep) else $error("failure in sleep");
	property p_irq;
		o_wake_irq |-> o_rxd_pull_low && $past(i_can_wake)
			&& $past(i_chip_mode) == sbcw_pkg::MODE_STOP;
	endproperty
	a_irq: assert property (p_irq) else $error("wake interrupt without stop wake");
	property p_rxd;
		$rose(o_rxd_pull_low) |-> o_wake_irq;
	endproperty
	a_rxd: assert property (p_rxd) else $error("receive pull without wake");
	property p_rdata;
		(!$past(i_rd) || $past(i_addr) > 8'h0c) |-> o_rdata == 8'h00;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule
bind sbcw_watchdog sbcw_watchdog_chk #(.CYC_PER_MS(CYC_PER_MS), .RESET_DELAY_MS(RESET_DELAY_MS))
	u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_rd(i_rd),
	.i_chip_mode(i_chip_mode), .i_dev_mode(i_dev_mode), .i_can_wake(i_can_wake),
	.o_rdata(o_rdata), .o_reset_output_pin(o_reset_output_pin), .o_wd_failure(o_wd_failure),
	.o_normal_request(o_normal_request), .o_wake_irq(o_wake_irq),
	.o_rxd_pull_low(o_rxd_pull_low));

// [verif/sbc_software_watchdog_tb.sv]
`timescale 1ns/1ns
module sbc_software_watchdog_tb;
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [7:0] addr, wdata, o_rdata, d, v;
	logic wr, rd, chip_select_n, pin, fail, fs, nreq, irq, rxd;
	logic [2:0] mode = sbcw_pkg::MODE_INIT;
	// Bench mode requests reach the mode stand-in, so mode has one driver
	logic [2:0] mode_sw = sbcw_pkg::MODE_INIT;
	logic [2:0] mode_sw_q = sbcw_pkg::MODE_INIT;
	logic dev = 1'b0;
	logic ro_rel = 1'b0;
	logic wake = 1'b0;
	int error_cnt = 0;
	int compares = 0;
	int fails = 0;
	int exp_fails = 0;
	always #20 i_core_clk = ~i_core_clk;
	sbcw_watchdog #(.CYC_PER_MS(10), .RESET_DELAY_MS(1)) uut (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(o_rdata), .i_chip_select_n(chip_select_n), .i_chip_mode(mode),
		.i_dev_mode(dev), .i_ro_released(ro_rel), .i_can_wake(wake), .o_reset_output_pin(pin),
		.o_wd_failure(fail), .o_fail_to_failsafe(fs), .o_normal_request(nreq),
		.o_wake_irq(irq), .o_rxd_pull_low(rxd));
	sbcw_host_model host (.i_core_clk(i_core_clk), .i_rdata(o_rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_chip_select_n(chip_select_n));
	// Stand-in for the chip mode controller
	always @(posedge i_core_clk) begin
		mode_sw_q <= mode_sw;
		if (mode_sw !== mode_sw_q) mode <= mode_sw;
		if (fail === 1'b1) mode <= fs ? sbcw_pkg::MODE_FAILSAFE : sbcw_pkg::MODE_RESTART;
		if (nreq === 1'b1) mode <= sbcw_pkg::MODE_NORMAL;
		if (fail === 1'b1) fails <= fails + 1;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_cmp(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		host.rd(a, d);
		cmp(d & m, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	task automatic chk_fail;
		exp_fails++;
		cmp(8'(fails), 8'(exp_fails));
	endtask
	task automatic wait_norm;
		for (int i = 0; i < 200 && nreq !== 1'b1; i++) @(posedge i_core_clk);
		cyc(1);
		cmp({5'h00, mode}, {5'h00, sbcw_pkg::MODE_NORMAL});
	endtask
	task automatic results;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#(40 * 40000);
		error_cnt++;
		results;
	end
	initial begin
		void'($urandom(85));
		cyc(4);
		i_reset_n <= 1'b1;
		// Init mode keeps the watchdog off until the reset output is released
		rd_cmp(8'h08, 8'h18, 8'h08);
		ro_rel <= 1'b1;
		rd_cmp(8'h00, 8'hff, 8'h84);
		rd_cmp(8'h04, 8'hff, 8'h02);
		rd_cmp(8'h10, 8'hff, 8'h00);
		rd_cmp(8'h08, 8'h18, 8'h10);
		cyc(2010);
		chk_fail;
		rd_cmp(8'h08, 8'h03, 8'h01);
		wait_norm;
		v = $urandom;
		v[7] = ~^v[6:0];
		host.trig(v);
		cyc(8);
		rd_cmp(8'h00, 8'hff, 8'h84);
		rd_cmp(8'h08, 8'h04, 8'h04);
		host.wr(8'h08, 8'h04);
		// Reserved bit written as 1 still counts in the checksum
		host.trig(8'h09);
		cyc(8);
		rd_cmp(8'h00, 8'hff, 8'h81);
		rd_cmp(8'h08, 8'h07, 8'h00);
		for (int i = 0; i < 6; i++) begin
			cyc(20 + $urandom % 50);
			host.trig(8'h09);
		end
		cyc(110);
		chk_fail;
		wait_norm;
		host.trig(8'h21);
		for (int i = 0; i < 4; i++) begin
			cyc(70 + $urandom % 15);
			host.trig(8'h21);
		end
		cyc(20);
		host.trig(8'h21);
		cyc(10);
		chk_fail;
		cmp({7'h00, pin}, 8'h00);
		wait_norm;
		for (int i = 0; i < 3; i++) begin
			host.wr(8'h0c, (i == 0) ? 8'h01 : 8'h00);
			cyc(2010);
			chk_fail;
			rd_cmp(8'h08, 8'h03, (i == 0) ? 8'h01 : 8'h02);
			wait_norm;
		end
		host.trig(8'h11);
		cyc(8);
		cmp({7'h00, fs}, 8'h01);
		cyc(110);
		chk_fail;
		rd_cmp(8'h08, 8'h03, 8'h01);
		wait_norm;
		host.trig(8'h81);
		mode_sw <= sbcw_pkg::MODE_SLEEP;
		cyc(2010);
		rd_cmp(8'h08, 8'h03, 8'h00);
		cmp(8'(fails), 8'(exp_fails));
		mode_sw <= sbcw_pkg::MODE_NORMAL;
		dev <= 1'b1;
		cyc(2010);
		cmp(8'(fails), 8'(exp_fails));
		dev <= 1'b0;
		host.trig(8'h41);
		cyc(8);
		rd_cmp(8'h00, 8'h40, 8'h00);
		host.wr(8'h04, 8'h03);
		host.trig(8'h41);
		rd_cmp(8'h04, 8'h03, 8'h03);
		rd_cmp(8'h00, 8'h40, 8'h40);
		mode_sw <= sbcw_pkg::MODE_STOP;
		cyc(2010);
		cmp(8'(fails), 8'(exp_fails));
		wake <= 1'b1;
		cyc(1);
		wake <= 1'b0;
		cyc(1);
		cmp({7'h00, irq}, 8'h01);
		cyc(2);
		cmp({7'h00, rxd}, 8'h01);
		rd_cmp(8'h00, 8'h40, 8'h00);
		cyc(2010);
		chk_fail;
		results;
	end
endmodule
